// ### tcc_timer.sv
`timescale 1ns/10ps
// Overview of operation
// - Clock select zero stops the counter
// - Upper count byte goes through staging register
// - Lower read stages upper; lower write loads
// - Count steps by one; clear zeroes all
// - Raise top and bottom indications
// - Each tick clears, increments or decrements
// - Counter accessible with or without tick
// - Software write beats clear or count
// - Sequence follows four-bit waveform mode field
// - Overflow flag set per mode, interrupts
// - Matching edge copies count into capture
// - Capture flag set with copy, interrupts
// - Capture flag clears on service or one
// - Capture lower read stages upper byte
// - Capture writable only when it is top
// - Comparator select picks comparator as source
// - Sources synchronised; filter adds five cycles
// - Capture inputs off in capture-top modes
// - Filter changes after four equal samples
// - Each capture overwrites the previous value
// - Top is fixed, compare A or capture
module tcc_timer #(
	parameter int ADDR_WIDTH     = 8,
	parameter int PRESCALE_WIDTH = 10
) (
	// Clock and reset
	input  wire logic                  ref_clk_in,
	input  wire logic                  rst_n_in,
	// Wishbone slave
	input  wire logic                  wb_cyc_in,
	input  wire logic                  wb_stb_in,
	input  wire logic                  wb_we_in,
	input  wire logic [ADDR_WIDTH-1:0] wb_adr_in,
	input  wire logic [31:0]           wb_dat_in,
	input  wire logic [3:0]            wb_sel_in,
	output logic      [31:0]           wb_dat_out,
	output logic                       wb_ack_out,
	// Pins and comparator
	input  wire logic                  external_count_pin_in,
	input  wire logic                  capture_pin_in,
	input  wire logic                  comparator_output_in,
	// Interrupt service
	input  wire logic                  overflow_irq_ack_in,
	input  wire logic                  capture_irq_ack_in,
	output logic                       overflow_irq_out,
	output logic                       capture_irq_out,
	// Counter indications
	output logic                       count_top_out,
	output logic                       count_bottom_out
);

	// Refused at elaboration: the prescaler must reach the widest tap
	if (PRESCALE_WIDTH < tcc_pkg::DIV1024_BITS || ADDR_WIDTH < 6 || ADDR_WIDTH > 32)
	begin : g_param_check
		$error("tcc_timer: unsupported parameter values");
	end

	function automatic logic div_hit(input logic [PRESCALE_WIDTH-1:0] p, input int nbits);
		logic hit;
		hit = 1'b1;
		for (int i = 0; i < tcc_pkg::DIV1024_BITS; i++)
			if (i < nbits)
				hit = hit & p[i];
		return hit;
	endfunction

	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmpa, input logic [15:0] cap);
		case (m)
			4'h1, 4'h5: top_of = tcc_pkg::TOP_8BIT;
			4'h2, 4'h6: top_of = tcc_pkg::TOP_9BIT;
			4'h3, 4'h7: top_of = tcc_pkg::TOP_10BIT;
			4'h4, 4'h9, 4'hB, 4'hF: top_of = cmpa;
			4'h8, 4'hA, 4'hC, 4'hE: top_of = cap;
			default: top_of = tcc_pkg::COUNT_MAX;
		endcase
	endfunction

	// Software registers
	logic [7:0]                control_a;
	logic [7:0]                control_b;
	logic                      cmp_select;
	logic                      overflow_en;
	logic                      capture_irq_enable;
	logic [7:0]                staging;
	logic [15:0]               count_value;
	logic [15:0]               capture_value;
	logic [15:0]               compare_value_a;
	logic                      overflow_flag;
	logic                      capture_flag;
	logic                      count_down;
	logic [PRESCALE_WIDTH-1:0] presc;

	// Synchronisers, filter, edge detector
	logic                                  ext_s1;
	logic                                  ext_s2;
	logic                                  ext_prev;
	logic                                  pin_s1;
	logic                                  pin_s2;
	logic                                  cmp_s1;
	logic                                  cmp_s2;
	logic [tcc_pkg::FILTER_SAMPLES-1:0]    samples;
	logic                                  filt_out;
	logic                                  edge_prev;

	// Bus decode
	wire        access    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	wire        wr        = access & wb_we_in & wb_sel_in[0];
	wire        rd        = access & ~wb_we_in;
	wire [7:0]  ofs       = 8'(wb_adr_in);
	wire [7:0]  wdata     = wb_dat_in[7:0];
	wire        wr_cnt_lo = wr && ofs == tcc_pkg::OFS_COUNT_LOWER;
	wire        wr_cap_lo = wr && ofs == tcc_pkg::OFS_CAPTURE_LOWER;
	wire        wr_cmp_lo = wr && ofs == tcc_pkg::OFS_COMPARE_LOWER;
	wire        wr_upper  = wr && (ofs == tcc_pkg::OFS_COUNT_UPPER || ofs == tcc_pkg::OFS_CAPTURE_UPPER
	                        || ofs == tcc_pkg::OFS_COMPARE_UPPER);
	wire        rd_cnt_lo = rd && ofs == tcc_pkg::OFS_COUNT_LOWER;
	wire        rd_cap_lo = rd && ofs == tcc_pkg::OFS_CAPTURE_LOWER;
	wire        wr_flags  = wr && ofs == tcc_pkg::OFS_FLAGS;

	// Mode and clock decode
	wire [2:0]  clk_sel   = control_b[tcc_pkg::CLK_SEL_POS +: 3];
	wire [3:0]  mode      = {control_b[tcc_pkg::WGM_HI_POS +: 2], control_a[tcc_pkg::WGM_LO_POS +: 2]};
	wire        edge_sel  = control_b[tcc_pkg::EDGE_SEL_BIT];
	wire        filter_en = control_b[tcc_pkg::FILTER_EN_BIT];
	wire [15:0] top_val   = top_of(mode, compare_value_a, capture_value);
	wire        cap_top   = mode == 4'h8 || mode == 4'hA || mode == 4'hC || mode == 4'hE;
	wire        dual      = mode == 4'h1 || mode == 4'h2 || mode == 4'h3 || (mode >= 4'h8 && mode <= 4'hB);
	wire        ctc       = mode == 4'h4 || mode == 4'hC;
	wire        at_top    = count_value == top_val;
	wire        at_bottom = count_value == tcc_pkg::VALUE16_RST;

	wire        ext_rise  = ext_s2 & ~ext_prev;
	wire        ext_fall  = ~ext_s2 & ext_prev;
	logic       tick;
	always_comb
	begin
		case (clk_sel)
			tcc_pkg::CS_SYSCLK:   tick = 1'b1;
			tcc_pkg::CS_DIV8:     tick = div_hit(presc, tcc_pkg::DIV8_BITS);
			tcc_pkg::CS_DIV64:    tick = div_hit(presc, tcc_pkg::DIV64_BITS);
			tcc_pkg::CS_DIV256:   tick = div_hit(presc, tcc_pkg::DIV256_BITS);
			tcc_pkg::CS_DIV1024:  tick = div_hit(presc, tcc_pkg::DIV1024_BITS);
			tcc_pkg::CS_EXT_FALL: tick = ext_fall;
			tcc_pkg::CS_EXT_RISE: tick = ext_rise;
			default:              tick = 1'b0;
		endcase
	end

	// Counting sequence
	wire        wrap      = !dual && (at_top || count_value == tcc_pkg::COUNT_MAX);
	wire        turn_down = dual && !count_down && at_top;
	wire        turn_up   = dual && count_down && at_bottom;
	wire        go_down   = turn_down || (count_down && !turn_up);
	wire [15:0] step_val  = wrap ? tcc_pkg::VALUE16_RST
	                      : go_down ? count_value - tcc_pkg::COUNT_ONE
	                      : count_value + tcc_pkg::COUNT_ONE;
	wire [15:0] next_count = wr_cnt_lo ? {staging, wdata}
	                       : tick ? step_val
	                       : count_value;
	wire        next_down = !dual ? 1'b0 : (tick && !wr_cnt_lo) ? go_down : count_down;
	wire        ovf_event = tick && (dual ? (count_down && at_bottom)
	                        : ctc ? count_value == tcc_pkg::COUNT_MAX : wrap);

	// Capture path
	wire        cap_src   = cmp_select ? cmp_s2 : pin_s2;
	wire        all_same  = &samples || ~|samples;
	wire        cap_level = filter_en ? filt_out : cap_src;
	wire        cap_hit   = !cap_top && cap_level != edge_prev && cap_level == edge_sel;

	// Flags: a set in the same cycle as a clear wins
	wire        ovf_clr   = overflow_irq_ack_in || (wr_flags && wdata[tcc_pkg::OVERFLOW_BIT]);
	wire        cap_clr   = capture_irq_ack_in || (wr_flags && wdata[tcc_pkg::CAPTURE_BIT]);
	wire        next_ovf  = ovf_event || (overflow_flag && !ovf_clr);
	wire        next_capf = cap_hit || (capture_flag && !cap_clr);

	logic [7:0] rd_byte;
	always_comb
	begin
		case (ofs)
			tcc_pkg::OFS_CONTROL_A:     rd_byte = control_a;
			tcc_pkg::OFS_CONTROL_B:     rd_byte = control_b;
			tcc_pkg::OFS_COUNT_LOWER:   rd_byte = count_value[7:0];
			tcc_pkg::OFS_COUNT_UPPER:   rd_byte = staging;
			tcc_pkg::OFS_CAPTURE_LOWER: rd_byte = capture_value[7:0];
			tcc_pkg::OFS_CAPTURE_UPPER: rd_byte = staging;
			tcc_pkg::OFS_COMPARE_LOWER: rd_byte = compare_value_a[7:0];
			tcc_pkg::OFS_COMPARE_UPPER: rd_byte = compare_value_a[15:8];
			tcc_pkg::OFS_FLAGS:         rd_byte = (8'(overflow_flag) << tcc_pkg::OVERFLOW_BIT)
			                                    | (8'(capture_flag) << tcc_pkg::CAPTURE_BIT);
			tcc_pkg::OFS_IRQ_ENABLE:    rd_byte = (8'(overflow_en) << tcc_pkg::OVERFLOW_BIT)
			                                    | (8'(capture_irq_enable) << tcc_pkg::CAPTURE_BIT);
			tcc_pkg::OFS_CMP_CTRL:      rd_byte = 8'(cmp_select) << tcc_pkg::CMP_SELECT_BIT;
			default:                    rd_byte = tcc_pkg::BYTE_RST;
		endcase
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_out <= access;
			wb_dat_out <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			control_a          <= tcc_pkg::CONTROL_A_RST;
			control_b          <= tcc_pkg::CONTROL_B_RST;
			cmp_select         <= 1'b0;
			overflow_en        <= 1'b0;
			capture_irq_enable <= 1'b0;
			compare_value_a    <= tcc_pkg::VALUE16_RST;
		end
		else if (wr)
		begin
			if (ofs == tcc_pkg::OFS_CONTROL_A)
				control_a <= wdata;
			if (ofs == tcc_pkg::OFS_CONTROL_B)
				control_b <= wdata;
			if (ofs == tcc_pkg::OFS_CMP_CTRL)
				cmp_select <= wdata[tcc_pkg::CMP_SELECT_BIT];
			if (ofs == tcc_pkg::OFS_IRQ_ENABLE)
			begin
				overflow_en        <= wdata[tcc_pkg::OVERFLOW_BIT];
				capture_irq_enable <= wdata[tcc_pkg::CAPTURE_BIT];
			end
			if (wr_cmp_lo)
				compare_value_a <= {staging, wdata};
		end
	end

	// One staging byte is shared by every 16-bit register
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			staging <= tcc_pkg::BYTE_RST;
		else if (wr_upper)
			staging <= wdata;
		else if (rd_cnt_lo)
			staging <= count_value[15:8];
		else if (rd_cap_lo)
			staging <= capture_value[15:8];
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			count_value <= tcc_pkg::VALUE16_RST;
			count_down  <= 1'b0;
			presc       <= '0;
		end
		else
		begin
			count_value <= next_count;
			count_down  <= next_down;
			presc       <= presc + PRESCALE_WIDTH'(1);
		end
	end

	// Capture value: software writes only where it sets the top
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			capture_value <= tcc_pkg::VALUE16_RST;
		else if (wr_cap_lo && cap_top)
			capture_value <= {staging, wdata};
		else if (cap_hit)
			capture_value <= count_value;
	end

	// Pins cross into this clock through two flops first
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			ext_s1    <= 1'b0;
			ext_s2    <= 1'b0;
			ext_prev  <= 1'b0;
			pin_s1    <= 1'b0;
			pin_s2    <= 1'b0;
			cmp_s1    <= 1'b0;
			cmp_s2    <= 1'b0;
			samples   <= '0;
			filt_out  <= 1'b0;
			edge_prev <= 1'b0;
		end
		else
		begin
			ext_s1    <= external_count_pin_in;
			ext_s2    <= ext_s1;
			ext_prev  <= ext_s2;
			pin_s1    <= capture_pin_in;
			pin_s2    <= pin_s1;
			cmp_s1    <= comparator_output_in;
			cmp_s2    <= cmp_s1;
			samples   <= {samples[tcc_pkg::FILTER_SAMPLES-2:0], cap_src};
			if (all_same)
				filt_out <= samples[0];
			edge_prev <= cap_level;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			overflow_flag    <= 1'b0;
			capture_flag     <= 1'b0;
			overflow_irq_out <= 1'b0;
			capture_irq_out  <= 1'b0;
			count_top_out    <= 1'b0;
			count_bottom_out <= 1'b0;
		end
		else
		begin
			overflow_flag    <= next_ovf;
			capture_flag     <= next_capf;
			overflow_irq_out <= next_ovf && overflow_en;
			capture_irq_out  <= next_capf && capture_irq_enable;
			count_top_out    <= at_top;
			count_bottom_out <= at_bottom;
		end
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	stop_no_count_a : assert property (
		clk_sel == tcc_pkg::CS_STOP && !wr_cnt_lo |=> count_value == $past(count_value))
		else $error("counter moved with no clock selected");

	write_priority_a : assert property (
		wr_cnt_lo |=> count_value == {$past(staging), $past(wdata)})
		else $error("counter write lost to count");

	count_step_a : assert property (
		tick && !wr_cnt_lo && !dual && !wrap |=> count_value == $past(count_value) + tcc_pkg::COUNT_ONE)
		else $error("single slope step is not plus one");

	read_stage_a : assert property (
		rd_cnt_lo && !wr_upper |=> staging == $past(count_value[15:8]))
		else $error("count lower read did not stage upper byte");

	capture_copy_a : assert property (
		cap_hit && !wr_cap_lo |=> capture_value == $past(count_value) && capture_flag)
		else $error("capture did not copy counter and set flag");

	capture_gate_a : assert property (
		cap_top |-> !cap_hit)
		else $error("capture in capture-top mode");

	filter_change_a : assert property (
		filt_out != $past(filt_out) |-> $past(all_same))
		else $error("filter changed without equal samples");

	flag_clear_a : assert property (
		wr_flags && wdata[tcc_pkg::CAPTURE_BIT] && !cap_hit |=> !capture_flag)
		else $error("capture flag not cleared by one");

	top_flag_a : assert property (
		at_top |=> count_top_out)
		else $error("top indication missing");

	dual_turn_a : assert property (
		turn_down && tick && !wr_cnt_lo |=> count_down ##0 count_value == $past(count_value) - tcc_pkg::COUNT_ONE)
		else $error("dual slope did not turn at top");

	cover_capture_c : cover property (cap_hit ##1 capture_irq_out);
	cover_overflow_c : cover property (ovf_event ##1 overflow_flag);
	cover_turn_c : cover property (turn_down ##[1:600] turn_up);
	cover_filter_c : cover property (filter_en && cap_hit);

endmodule

// ### tcc_pkg.sv
package tcc_pkg;

	// Register word offsets (byte addresses)
	localparam logic [7:0] OFS_CONTROL_A      = 8'h00;
	localparam logic [7:0] OFS_CONTROL_B      = 8'h04;
	localparam logic [7:0] OFS_COUNT_LOWER    = 8'h08;
	localparam logic [7:0] OFS_COUNT_UPPER    = 8'h0C;
	localparam logic [7:0] OFS_CAPTURE_LOWER  = 8'h10;
	localparam logic [7:0] OFS_CAPTURE_UPPER  = 8'h14;
	localparam logic [7:0] OFS_COMPARE_LOWER  = 8'h18;
	localparam logic [7:0] OFS_COMPARE_UPPER  = 8'h1C;
	localparam logic [7:0] OFS_FLAGS          = 8'h20;
	localparam logic [7:0] OFS_IRQ_ENABLE     = 8'h24;
	localparam logic [7:0] OFS_CMP_CTRL       = 8'h28;

	// Field positions
	localparam int WGM_LO_POS      = 0;
	localparam int CLK_SEL_POS     = 0;
	localparam int WGM_HI_POS      = 3;
	localparam int EDGE_SEL_BIT    = 6;
	localparam int FILTER_EN_BIT   = 7;
	localparam int OVERFLOW_BIT    = 0;
	localparam int CAPTURE_BIT     = 5;
	localparam int CMP_SELECT_BIT  = 2;

	// Reset values
	localparam logic [7:0]  CONTROL_A_RST = 8'h00;
	localparam logic [7:0]  CONTROL_B_RST = 8'h00;
	localparam logic [15:0] VALUE16_RST   = 16'h0000;
	localparam logic [7:0]  BYTE_RST      = 8'h00;

	// Clock select codes
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_SYSCLK   = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// Prescaler tap widths: divide by two to the power of these
	localparam int DIV8_BITS    = 3;
	localparam int DIV64_BITS   = 6;
	localparam int DIV256_BITS  = 8;
	localparam int DIV1024_BITS = 10;

	// Fixed top values and extremes
	localparam logic [15:0] TOP_8BIT  = 16'h00FF;
	localparam logic [15:0] TOP_9BIT  = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE = 16'h0001;

	// Filter depth
	localparam int FILTER_SAMPLES = 4;

endpackage

// ### tcc_pin_model.sv
`timescale 1ns/10ps
module tcc_pin_model (
	// Clock
	input  wire logic clk_in,
	// Pins toward the timer
	output logic      capture_pin_out,
	output logic      comparator_output_out,
	output logic      external_count_pin_out
);
	initial
	begin
		capture_pin_out        = 1'h1;
		comparator_output_out  = 1'h1;
		external_count_pin_out = 1'h0;
	end

	// Levels move only after an edge; hold sets how slowly the source changes
	task automatic set_pins(input logic cap, input logic cmp, input int hold);
		@(posedge clk_in);
		capture_pin_out       <= cap;
		comparator_output_out <= cmp;
		repeat (hold) @(posedge clk_in);
	endtask

	// Pulses held at least three cycles each way so the synchroniser sees every one
	task automatic pulse_ext(input int count);
		repeat (count)
		begin
			@(posedge clk_in);
			external_count_pin_out <= 1'h1;
			repeat (3) @(posedge clk_in);
			external_count_pin_out <= 1'h0;
			repeat (3) @(posedge clk_in);
		end
	endtask
endmodule

// ### timer16_counter_capture_tb.sv
`timescale 1ns/10ps
module timer16_counter_capture_tb;
	localparam logic [7:0] CA = tcc_pkg::OFS_CONTROL_A;
	localparam logic [7:0] CB = tcc_pkg::OFS_CONTROL_B;
	localparam logic [7:0] CL = tcc_pkg::OFS_COUNT_LOWER;
	localparam logic [7:0] CU = tcc_pkg::OFS_COUNT_UPPER;
	localparam logic [7:0] PL = tcc_pkg::OFS_CAPTURE_LOWER;
	localparam logic [7:0] PU = tcc_pkg::OFS_CAPTURE_UPPER;
	localparam logic [7:0] AL = tcc_pkg::OFS_COMPARE_LOWER;
	localparam logic [7:0] AU = tcc_pkg::OFS_COMPARE_UPPER;
	localparam logic [7:0] FL = tcc_pkg::OFS_FLAGS;
	localparam logic [7:0] EN = tcc_pkg::OFS_IRQ_ENABLE;
	localparam logic [7:0] CC = tcc_pkg::OFS_CMP_CTRL;

	logic        clk;
	logic        rst_n;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        ov_ack;
	logic        cap_ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat;
	logic [31:0] rdat;
	logic [31:0] v;
	logic [31:0] dat_o;
	logic        ack;
	logic        ov_irq;
	logic        cap_irq;
	logic        top;
	logic        bot;
	logic        cap_pin;
	logic        cmp_out;
	logic        ext_pin;
	logic [32:0] m;
	logic [32:0] notes[$];
	int          num_errors;
	int          compares;

	tcc_timer u_tcc_timer (
		.ref_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel), .wb_dat_out(dat_o), .wb_ack_out(ack),
		.external_count_pin_in(ext_pin), .capture_pin_in(cap_pin), .comparator_output_in(cmp_out),
		.overflow_irq_ack_in(ov_ack), .capture_irq_ack_in(cap_ack), .overflow_irq_out(ov_irq),
		.capture_irq_out(cap_irq), .count_top_out(top), .count_bottom_out(bot)
	);

	tcc_pin_model u_tcc_pin_model (
		.clk_in(clk), .capture_pin_out(cap_pin), .comparator_output_out(cmp_out),
		.external_count_pin_out(ext_pin)
	);

	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One classic cycle; the expected read byte is noted for the monitor
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic c,
		input logic [7:0] e);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we  <= w;
		adr <= a;
		sel <= 4'h1;
		dat <= {24'h00_0000, d};
		notes.push_back({c, 24'h00_0000, e});
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'h1 && n < 50);
		if (ack !== 1'h1)
			num_errors++;
		rdat = dat_o;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'h1, a, d, 1'h0, 8'h00);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(1'h0, a, 8'h00, 1'h1, e);
	endtask

	// Level pulse on an interrupt service line
	task automatic svc(input logic ovf);
		@(posedge clk);
		if (ovf)
			ov_ack <= 1'h1;
		else
			cap_ack <= 1'h1;
		@(posedge clk);
		ov_ack  <= 1'h0;
		cap_ack <= 1'h0;
		repeat (2) @(posedge clk);
	endtask

	always @(negedge clk)
		if (ack === 1'h1 && notes.size() > 0)
		begin
			m = notes.pop_front();
			if (m[32])
				check(dat_o, {24'h00_0000, m[7:0]});
		end

	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_sim();
	end

	initial
	begin
		rst_n = 1'h0; cyc = 1'h0; stb = 1'h0; we = 1'h0; adr = 8'h00; sel = 4'h1;
		dat = 32'h0000_0000; ov_ack = 1'h0; cap_ack = 1'h0; num_errors = 0; compares = 0;
		void'($urandom(32'he7c2_bae9));
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		rd(CA, 8'h00);
		rd(CB, 8'h00);
		wr(8'h3C, 8'hFF);
		rd(8'h3C, 8'h00);
		repeat (20) @(posedge clk);
		rd(CL, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			v = $urandom;
			wr(CU, v[15:8]);
			wr(CL, v[7:0]);
			rd(CL, v[7:0]);
			rd(CU, v[15:8]);
		end
		wr(CU, 8'h00);
		wr(CL, 8'h00);
		@(negedge clk);
		check({31'h0000_0000, bot}, 32'h0000_0001);
		wr(CU, 8'hFF);
		wr(CL, 8'hFF);
		@(negedge clk);
		check({31'h0000_0000, top}, 32'h0000_0001);
		// Staged upper byte reused for two lower writes
		wr(CU, 8'h9A);
		wr(AL, 8'h01);
		wr(CL, 8'h02);
		rd(AU, 8'h9A);
		rd(CL, 8'h02);
		rd(CU, 8'h9A);
		// Write while running wins, then a few single steps
		wr(CB, {5'h00, tcc_pkg::CS_SYSCLK});
		wr(CU, 8'h40);
		wr(CL, 8'h00);
		wr(CB, 8'h00);
		acc(1'h0, CL, 8'h00, 1'h0, 8'h00);
		check({31'h0000_0000, rdat[7:0] >= 8'h01 && rdat[7:0] <= 8'h04}, 32'h0000_0001);
		v = rdat;
		rd(CU, 8'h40);
		repeat (20) @(posedge clk);
		rd(CL, v[7:0]);
		// Wrap through maximum
		wr(CU, 8'hFF);
		wr(CL, 8'hFE);
		wr(CB, {5'h00, tcc_pkg::CS_SYSCLK});
		wr(CB, 8'h00);
		rd(FL, 8'h01);
		wr(EN, 8'h01);
		@(negedge clk);
		check({31'h0000_0000, ov_irq}, 32'h0000_0001);
		svc(1'h1);
		rd(FL, 8'h00);
		// Pin capture, falling edge after reset
		wr(EN, 8'h20);
		wr(CU, 8'hAB);
		wr(CL, 8'hCD);
		u_tcc_pin_model.set_pins(1'h0, 1'h1, 12);
		@(negedge clk);
		check({31'h0000_0000, cap_irq}, 32'h0000_0001);
		rd(FL, 8'h20);
		rd(PL, 8'hCD);
		rd(PU, 8'hAB);
		svc(1'h0);
		rd(FL, 8'h00);
		wr(CU, 8'h56);
		wr(CL, 8'h78);
		u_tcc_pin_model.set_pins(1'h1, 1'h1, 12);
		rd(FL, 8'h00);
		wr(CB, 8'h40);
		u_tcc_pin_model.set_pins(1'h0, 1'h1, 6);
		u_tcc_pin_model.set_pins(1'h1, 1'h1, 12);
		rd(PL, 8'h78);
		rd(PU, 8'h56);
		wr(FL, 8'h00);
		rd(FL, 8'h20);
		wr(FL, 8'h20);
		rd(FL, 8'h00);
		// Comparator as source; flag cleared after the switch
		wr(CC, 8'h04);
		u_tcc_pin_model.set_pins(1'h1, 1'h0, 12);
		wr(FL, 8'h20);
		wr(CU, 8'h01);
		wr(CL, 8'h02);
		u_tcc_pin_model.set_pins(1'h1, 1'h1, 12);
		rd(PL, 8'h02);
		wr(CC, 8'h00);
		wr(FL, 8'h20);
		// Filter rejects a short glitch
		wr(CB, 8'hC0);
		u_tcc_pin_model.set_pins(1'h0, 1'h1, 12);
		wr(CU, 8'h03);
		wr(CL, 8'h04);
		u_tcc_pin_model.set_pins(1'h1, 1'h1, 1);
		u_tcc_pin_model.set_pins(1'h0, 1'h1, 12);
		rd(FL, 8'h00);
		u_tcc_pin_model.set_pins(1'h1, 1'h1, 14);
		rd(PL, 8'h04);
		wr(FL, 8'h20);
		// Capture writes only in capture-top modes
		wr(CB, 8'h00);
		wr(PU, 8'h11);
		wr(PL, 8'h22);
		rd(PL, 8'h04);
		wr(CB, 8'h18);
		wr(PU, 8'h11);
		wr(PL, 8'h22);
		rd(PL, 8'h22);
		rd(PU, 8'h11);
		u_tcc_pin_model.set_pins(1'h0, 1'h1, 12);
		rd(FL, 8'h00);
		rd(PL, 8'h22);
		// Dual slope: turn at top, overflow at bottom
		wr(CA, 8'h01);
		wr(CU, 8'h00);
		wr(CL, 8'hFE);
		wr(CB, {5'h00, tcc_pkg::CS_SYSCLK});
		wr(CB, 8'h00);
		rd(CL, 8'hFD);
		wr(CL, 8'h02);
		wr(CB, {5'h00, tcc_pkg::CS_SYSCLK});
		wr(CB, 8'h00);
		rd(FL, 8'h01);
		rd(CL, 8'h01);
		wr(FL, 8'h01);
		// Prescaled clock: 83 system edges give 10 or 11 ticks at divide by 8
		wr(CA, 8'h00);
		wr(CU, 8'h00);
		wr(CL, 8'h00);
		wr(CB, {5'h00, tcc_pkg::CS_DIV8});
		repeat (80) @(posedge clk);
		wr(CB, 8'h00);
		acc(1'h0, CL, 8'h00, 1'h0, 8'h00);
		check({31'h0000_0000, rdat[7:0] >= 8'h0A && rdat[7:0] <= 8'h0B}, 32'h0000_0001);
		// External pin, rising edges
		wr(CL, 8'h00);
		wr(CB, {5'h00, tcc_pkg::CS_EXT_RISE});
		u_tcc_pin_model.pulse_ext(3);
		wr(CB, 8'h00);
		rd(CL, 8'h03);
		end_sim();
	end
endmodule
